/* tpv_pkg.sv */
// shared constants and types of the tape position value datapath
package tpv_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SCALE = 8'h04;
  localparam logic [7:0] OFF_OFFSET = 8'h08;
  localparam logic [7:0] OFF_PRESET = 8'h0C;
  localparam logic [7:0] OFF_MIN = 8'h10;
  localparam logic [7:0] OFF_MAX = 8'h14;
  localparam logic [7:0] OFF_POS = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  // control register fields
  localparam int CTL_DEPTH_LSB = 0;
  localparam int CTL_PMODE_LSB = 8;
  localparam int CTL_SAVE_LSB = 10;
  localparam int CTL_DIR_BIT = 12;
  localparam int CTL_RES_LSB = 16;
  localparam int CTL_RESTART_BIT = 31;
  // status register fields
  localparam int STA_PRESET_BIT = 0;
  localparam int STA_BUSY_BIT = 1;
  localparam int STA_TEACH_BIT = 2;
  // setting codes and reset values
  localparam logic [5:0] DEPTH_MIN = 6'h04;
  localparam logic [5:0] DEPTH_DEF = 6'h08;
  localparam logic [5:0] DEPTH_MAX = 6'h20;
  localparam logic [1:0] PMODE_OFF = 2'h1;
  localparam logic [1:0] PMODE_ON = 2'h2;
  localparam logic [1:0] SAVE_PERM = 2'h1;
  localparam logic [1:0] SAVE_TEMP = 2'h2;
  localparam logic DIR_INV = 1'b1;
  localparam logic [2:0] RES_DEF = 3'h3;
  localparam logic [31:0] CTRL_DEF = {13'h0000, RES_DEF, 3'h0, 1'b0, SAVE_PERM,
                                      PMODE_OFF, 2'h0, DEPTH_DEF};
  localparam logic [15:0] SCALE_DEF = 16'h03E8;
  localparam logic [31:0] OFFSET_DEF = 32'h0000_0000;
  localparam logic [31:0] PRESET_DEF = 32'h0000_0000;
  localparam logic [31:0] MIN_DEF = 32'h0000_0000;
  localparam logic [31:0] MAX_DEF = 32'h0098_9680;
  // internal unit: raw scans are 0.01 mm, scaled values 1e-5 mm at factor 1000
  localparam logic signed [63:0] HUND_PER_MM = 64'sh64;
  localparam logic signed [63:0] XU_PER_MM = 64'sh1_86A0;
  localparam logic [63:0] SCALE_DEN = 64'h3E8;
  localparam logic signed [63:0] FULL_MM = 64'sh98_9680;
  // integration step timing
  localparam real STEP_TIME_MS = 3.3;
  localparam real CLK_PERIOD_NS = 8.0;
  localparam int STEP_CYC = int'(STEP_TIME_MS * 1.0E6 / CLK_PERIOD_NS);
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_AVG = 4'h2,
    ST_CALC = 4'h4,
    ST_RND = 4'h8
  } tpv_state_t;
  // resolution code to divisor in 0.01 mm steps, unknown codes act as 1 mm
  function automatic logic [63:0] res_div(input logic [2:0] code);
    case (code)
      3'h1: res_div = 64'h1;
      3'h2: res_div = 64'hA;
      3'h4: res_div = 64'h3E8;
      3'h5: res_div = 64'h2710;
      3'h6: res_div = 64'h1_86A0;
      default: res_div = 64'h64;
    endcase
  endfunction
endpackage

/* tpv_div.sv */
// sequential restoring unsigned divider
`timescale 1ns/1ps
`default_nettype none
module tpv_div #(
  parameter int W = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  // answer
  output logic busy,
  output logic done,
  output logic [W-1:0] quo
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cnt;
    logic [W-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] den;
  } tpv_div_st_t;
  tpv_div_st_t s, n;
  logic [W:0] t;
  ////////////////////////////////////////////////////////////////////////////
  // one quotient bit per cycle; a zero divisor yields all ones, callers avoid it
  always_comb begin
    n = s;
    n.done = 1'b0;
    t = {s.rem, s.quo[W-1]};
    if (s.busy) begin
      if (t >= {1'b0, s.den}) begin
        n.rem = W'(t - {1'b0, s.den});
        n.quo = {s.quo[W-2:0], 1'b1};
      end else begin
        n.rem = t[W-1:0];
        n.quo = {s.quo[W-2:0], 1'b0};
      end
      n.cnt = s.cnt - 8'h01;
      if (s.cnt == 8'h01) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end else if (start) begin
      n.busy = 1'b1;
      n.rem = '0;
      n.quo = num;
      n.den = den;
      n.cnt = 8'(W);
    end
  end
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign busy = s.busy;
  assign done = s.done;
  assign quo = s.quo;
endmodule // tpv_div
`default_nettype wire

/* tpv_integ.sv */
// integration of consecutive raw scans, one per step
`timescale 1ns/1ps
`default_nettype none
module tpv_integ #(
  parameter int STEP_CYC = 412500,
  parameter int SW = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic restart,
  input wire logic [5:0] depth,
  // raw scans
  input wire logic [31:0] scan_pos,
  input wire logic scan_valid,
  // sum of depth scans
  output logic [SW-1:0] sum,
  output logic done
);
  typedef struct packed {
    logic [31:0] tmr;
    logic [5:0] cnt;
    logic [SW-1:0] acc;
    logic [31:0] last;
    logic have;
    logic [SW-1:0] sum;
    logic done;
  } tpv_integ_st_t;
  tpv_integ_st_t s, n;
  ////////////////////////////////////////////////////////////////////////////
  // each step takes the latest scan; a step without a scan is skipped, so a
  // window stretches rather than average stale data
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (restart) begin
      n.tmr = '0;
      n.cnt = '0;
      n.acc = '0;
      n.have = 1'b0;
    end else begin
      if (s.tmr == 32'(STEP_CYC - 1)) begin
        n.tmr = '0;
        n.have = 1'b0;
        if (s.have) begin
          if (s.cnt + 6'h01 >= depth) begin
            n.sum = s.acc + SW'(s.last);
            n.done = 1'b1;
            n.acc = '0;
            n.cnt = '0;
          end else begin
            n.acc = s.acc + SW'(s.last);
            n.cnt = s.cnt + 6'h01;
          end
        end
      end else begin
        n.tmr = s.tmr + 32'h1;
      end
      if (scan_valid) begin
        n.last = scan_pos;
        n.have = 1'b1;
      end
    end
  end
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign sum = s.sum;
  assign done = s.done;
endmodule // tpv_integ
`default_nettype wire

/* tpv_top.sv */
// position value datapath with register slave
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tpv_top
  import tpv_pkg::*;
#(
  parameter int STEP_CYC = tpv_pkg::STEP_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register bus, write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // register bus, read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // raw scans in 0.01 mm from the decoder
  input wire logic [31:0] SCAN_POS,
  input wire logic SCAN_VALID,
  // switching input pin, teach on rising edge
  input wire logic SW_IN,
  // position to the host side, in resolution steps
  output logic [31:0] POS_VALUE,
  output logic POS_VALID,
  output logic PRESET_ACTIVE
);
  typedef struct packed {
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [15:0] scale;
    logic [31:0] offset;
    logic [31:0] preset;
    logic [31:0] minl;
    logic [31:0] maxl;
    tpv_state_t st;
    logic restart;
    logic teach_pend;
    logic preset_act;
    logic signed [63:0] anchor;
    logic [31:0] tape;
    logic [31:0] pos;
    logic pos_valid;
    logic avg_go;
    logic rnd_go;
    logic [63:0] rnd_num;
    logic [63:0] rnd_den;
    logic sw_q1;
    logic sw_q2;
    logic sw_q3;
  } tpv_top_st_t;
  tpv_top_st_t s, n;
  logic rst_q1, rst_q2;
  logic [39:0] int_sum;
  logic int_done;
  logic avg_done;
  logic [63:0] avg_quo;
  logic rnd_done;
  logic [63:0] rnd_quo;
  logic [5:0] depth;
  logic [1:0] pmode;
  logic preset_on;
  logic signed [63:0] tape_s, off_s, raw_x, val, lo_x, hi_x;
  logic [63:0] den;
  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        old[8*i +: 8] = d[8*i +: 8];
      end
    end
    return old;
  endfunction
  // depth outside 4..32 is pulled to the nearest bound
  function automatic logic [5:0] clamp_depth(input logic [5:0] d);
    if (d < DEPTH_MIN) begin
      return DEPTH_MIN;
    end
    if (d > DEPTH_MAX) begin
      return DEPTH_MAX;
    end
    return d;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops, assertion stays asynchronous
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // scan integration and the two dividers
  assign depth = s.ctrl[CTL_DEPTH_LSB +: 6];
  assign pmode = s.ctrl[CTL_PMODE_LSB +: 2];
  assign preset_on = (pmode == PMODE_ON);
  tpv_integ #(.STEP_CYC(STEP_CYC), .SW(40)) u_integ (
    .clk(CORE_CLK),
    .rst_n(rst_q2),
    .restart(s.restart),
    .depth(depth),
    .scan_pos(SCAN_POS),
    .scan_valid(SCAN_VALID),
    .sum(int_sum),
    .done(int_done)
  );
  tpv_div #(.W(64)) u_avg (
    .clk(CORE_CLK),
    .rst_n(rst_q2),
    .start(s.avg_go),
    .num({24'h00_0000, int_sum}),
    .den({58'h0, depth}),
    .busy(),
    .done(avg_done),
    .quo(avg_quo)
  );
  tpv_div #(.W(64)) u_rnd (
    .clk(CORE_CLK),
    .rst_n(rst_q2),
    .start(s.rnd_go),
    .num(s.rnd_num),
    .den(s.rnd_den),
    .busy(),
    .done(rnd_done),
    .quo(rnd_quo)
  );
  ////////////////////////////////////////////////////////////////////////////
  // position arithmetic, all in 1e-5 mm units at factor 1000
  always_comb begin
    tape_s = $signed({32'h0000_0000, s.tape});
    off_s = 64'($signed(s.offset)) * HUND_PER_MM;
    raw_x = tape_s * $signed({48'h0, s.scale});
    if (s.teach_pend && preset_on) begin
      val = 64'($signed({32'h0000_0000, s.preset})) * XU_PER_MM;
    end else if (s.preset_act) begin
      // offset drops out while the preset holds the reference
      val = 64'($signed({32'h0000_0000, s.preset})) * XU_PER_MM
            + raw_x - s.anchor;
    end else begin
      val = (tape_s + off_s) * $signed({48'h0, s.scale});
    end
    if (s.ctrl[CTL_DIR_BIT] == DIR_INV) begin
      val = FULL_MM * XU_PER_MM - val;
    end
    lo_x = 64'($signed({32'h0000_0000, s.minl})) * XU_PER_MM;
    hi_x = 64'($signed({32'h0000_0000, s.maxl})) * XU_PER_MM;
    den = SCALE_DEN * res_div(s.ctrl[CTL_RES_LSB +: 3]);
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus slave, teach capture and sequencer
  always_comb begin
    n = s;
    n.restart = 1'b0;
    n.avg_go = 1'b0;
    n.rnd_go = 1'b0;
    n.pos_valid = 1'b0;
    // teach edge only from the synchronised switching input
    n.sw_q1 = SW_IN;
    n.sw_q2 = s.sw_q1;
    n.sw_q3 = s.sw_q2;
    if (s.sw_q2 && !s.sw_q3 && preset_on) begin
      n.teach_pend = 1'b1;
    end
    // write address and data are taken in either order
    if (S_AXI_AWVALID && !s.aw_ok) begin
      n.aw_ok = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s.w_ok) begin
      n.w_ok = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (s.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (s.awaddr)
        OFF_CTRL: begin
          n.ctrl = wmerge(s.ctrl, s.wdata, s.wstrb);
          n.ctrl[CTL_DEPTH_LSB +: 6] = clamp_depth(n.ctrl[CTL_DEPTH_LSB +: 6]);
          n.restart = n.ctrl[CTL_RESTART_BIT];
          n.ctrl[CTL_RESTART_BIT] = 1'b0;
        end
        OFF_SCALE: n.scale = 16'(wmerge({16'h0000, s.scale}, s.wdata, s.wstrb));
        OFF_OFFSET: n.offset = wmerge(s.offset, s.wdata, s.wstrb);
        OFF_PRESET: n.preset = wmerge(s.preset, s.wdata, s.wstrb);
        OFF_MIN: n.minl = wmerge(s.minl, s.wdata, s.wstrb);
        OFF_MAX: n.maxl = wmerge(s.maxl, s.wdata, s.wstrb);
        OFF_POS, OFF_STAT: n.bresp = RESP_OKAY; // read-only, write ignored
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // one read in flight; data captured at the address handshake
    if (s.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (S_AXI_ARADDR)
        OFF_CTRL: n.rdata = s.ctrl;
        OFF_SCALE: n.rdata = {16'h0000, s.scale};
        OFF_OFFSET: n.rdata = s.offset;
        OFF_PRESET: n.rdata = s.preset;
        OFF_MIN: n.rdata = s.minl;
        OFF_MAX: n.rdata = s.maxl;
        OFF_POS: n.rdata = s.pos;
        OFF_STAT: begin
          n.rdata = '0;
          n.rdata[STA_PRESET_BIT] = s.preset_act;
          n.rdata[STA_BUSY_BIT] = (s.st != ST_IDLE);
          n.rdata[STA_TEACH_BIT] = s.teach_pend;
        end
        default: begin
          n.rdata = '0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    // a taught preset is dropped when preset mode is turned off, or by a restart while saving is temporary
    if (!preset_on) begin
      n.preset_act = 1'b0;
      n.teach_pend = 1'b0;
    end
    // restart keeps a permanent preset and forgets a temporary one
    if (s.restart && s.ctrl[CTL_SAVE_LSB +: 2] == SAVE_TEMP) begin
      n.preset_act = 1'b0;
    end
    // sequencer: mean, arithmetic, limits, rounding
    case (s.st)
      ST_IDLE: begin
        if (int_done) begin
          n.avg_go = 1'b1;
          n.st = ST_AVG;
        end
      end
      ST_AVG: begin
        if (avg_done) begin
          n.tape = avg_quo[31:0];
          n.st = ST_CALC;
        end
      end
      ST_CALC: begin
        if (s.teach_pend && preset_on) begin
          n.anchor = raw_x;
          n.preset_act = 1'b1;
          n.teach_pend = s.sw_q2 && !s.sw_q3; // an edge landing now stays armed
        end
        if (val < lo_x || val > hi_x) begin
          n.pos = '0;
          n.pos_valid = 1'b1;
          n.st = ST_IDLE;
        end else begin
          n.rnd_num = 64'(val) + (den >> 1);
          n.rnd_den = den;
          n.rnd_go = 1'b1;
          n.st = ST_RND;
        end
      end
      ST_RND: begin
        if (rnd_done) begin
          n.pos = rnd_quo[31:0];
          n.pos_valid = 1'b1;
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (s.restart) begin
      n.st = ST_IDLE;
    end
  end
  // state register; configuration and sequencer reset together
  always_ff @(posedge CORE_CLK or negedge rst_q2) begin
    if (!rst_q2) begin
      s <= '0;
      s.ctrl <= CTRL_DEF;
      s.scale <= SCALE_DEF;
      s.offset <= OFFSET_DEF;
      s.preset <= PRESET_DEF;
      s.minl <= MIN_DEF;
      s.maxl <= MAX_DEF;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign S_AXI_AWREADY = !s.aw_ok;
  assign S_AXI_WREADY = !s.w_ok;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = !s.rvalid;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;
  assign POS_VALUE = s.pos;
  assign POS_VALID = s.pos_valid;
  assign PRESET_ACTIVE = s.preset_act;
endmodule // tpv_top
`default_nettype wire

/* tpv_top_props.sv */
// port-level assertions for the position value datapath
`timescale 1ns/1ps
`default_nettype none
module tpv_top_props (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // teach and position
  input wire logic SW_IN,
  input wire logic [31:0] POS_VALUE,
  input wire logic POS_VALID,
  input wire logic PRESET_ACTIVE
);
  logic sw_d;
  logic sw_seen;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // a switching edge stays armed until a preset takes effect, so each preset needs its own edge
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_d <= 1'b0;
      sw_seen <= 1'b0;
    end else begin
      sw_d <= SW_IN;
      if (SW_IN && !sw_d) begin
        sw_seen <= 1'b1;
      end else if (PRESET_ACTIVE) begin
        sw_seen <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bus handshakes as steps
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_rd_bad;
    S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR > 8'h1C);
  endsequence
  AST_TEACH_SRC: assert property ($rose(PRESET_ACTIVE) |-> sw_seen)
    else $error("preset became active without a switching edge");
  AST_POS_PULSE: assert property (POS_VALID |=> !POS_VALID)
    else $error("position strobe longer than one cycle");
  AST_POS_HOLD: assert property ($changed(POS_VALUE) |-> POS_VALID)
    else $error("position changed without strobe");
  AST_B_ANSWER: assert property (s_wr_take |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  AST_R_ANSWER: assert property (s_rd_take |=> S_AXI_RVALID)
    else $error("read data late");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while data pending");
  AST_UNMAPPED_RD: assert property (s_rd_bad |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
endmodule // tpv_top_props
bind tpv_top tpv_top_props u_props (
  .CORE_CLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
  .SW_IN, .POS_VALUE, .POS_VALID, .PRESET_ACTIVE
);
`default_nettype wire

/* tpv_host_model.sv */
// host side model that collects position values
`timescale 1ns/1ps
`default_nettype none
module tpv_host_model (
  // clock
  input wire logic clk,
  // position from the device
  input wire logic [31:0] pos_value,
  input wire logic pos_valid,
  // collected results
  output logic [31:0] last_pos,
  output logic [31:0] pos_count,
  output logic [31:0] gap
);
  logic [31:0] since;
  initial begin
    last_pos = 32'h0;
    pos_count = 32'h0;
    gap = 32'h0;
    since = 32'h0;
  end
  // the value is only taken in the strobe cycle, as a real host would
  always @(posedge clk) begin
    since <= since + 32'h1;
    if (pos_valid) begin
      last_pos <= pos_value;
      pos_count <= pos_count + 32'h1;
      gap <= since + 32'h1;
      since <= 32'h0;
    end
  end
endmodule // tpv_host_model
`default_nettype wire

/* tb.sv */
// self-checking testbench of the position value datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpv_pkg::*;
  localparam int STEP = 20;
  localparam int LIMIT = 60000;
  localparam logic [31:0] TAPE = 32'h0007_A120; // 5000 mm in 0.01 mm
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sw, pos_valid, preset_active;
  logic scan_valid = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, scan, pos_value, last_pos, pos_count, gap;
  logic [1:0] bresp, rresp;
  logic [2:0] sdiv = 3'h0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  tpv_top #(.STEP_CYC(STEP)) u_dut (
    .CORE_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SCAN_POS(scan), .SCAN_VALID(scan_valid), .SW_IN(sw),
    .POS_VALUE(pos_value), .POS_VALID(pos_valid), .PRESET_ACTIVE(preset_active)
  );
  tpv_host_model u_host (
    .clk(clk), .pos_value(pos_value), .pos_valid(pos_valid),
    .last_pos(last_pos), .pos_count(pos_count), .gap(gap)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one scan every five cycles, so every step has a fresh scan
  always @(posedge clk) begin
    sdiv <= (sdiv == 3'h4) ? 3'h0 : sdiv + 3'h1;
    scan_valid <= (sdiv == 3'h0);
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus tasks sample at the falling edge, where ready and valid equal the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    b = 1'b0; n = 0;
    while (!b && n < 100) begin
      @(negedge clk);
      aw = awvalid & awready; w = wvalid & wready; b = bvalid & bready;
      if (b) chk({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      n++;
    end
    if (!b) num_errors++;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    r = 1'b0; n = 0;
    while (!r && n < 100) begin
      @(negedge clk);
      ar = arvalid & arready; r = rvalid & rready;
      if (r) chk(rdata, ed);
      if (r) chk({30'h0, rresp}, {30'h0, er});
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
      n++;
    end
    if (!r) num_errors++;
  endtask
  // waits for n fresh positions, so the last one saw only the new settings
  task automatic wait_pos(input int n, input logic [31:0] exp);
    logic [31:0] k;
    int g;
    @(negedge clk);
    k = pos_count + n; g = 0;
    while (pos_count != k && g < 5000) begin
      @(posedge clk);
      g++;
    end
    @(negedge clk);
    chk(pos_count, k);
    chk(last_pos, exp);
  endtask
  function automatic logic [31:0] mk_ctrl(input logic [5:0] dp, input logic [1:0] pm,
      input logic [1:0] sv, input logic dr, input logic [2:0] rs);
    return {13'h0, rs, 3'h0, dr, sv, pm, 2'h0, dp};
  endfunction
  task automatic pulse_sw();
    @(posedge clk) sw <= 1'b1;
    repeat (10) @(posedge clk);
    sw <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(OFF_CTRL, CTRL_DEF, RESP_OKAY);
    axi_rd(OFF_SCALE, 32'h3E8, RESP_OKAY);
    axi_rd(OFF_OFFSET, 32'h0, RESP_OKAY);
    axi_rd(OFF_PRESET, 32'h0, RESP_OKAY);
    axi_rd(OFF_MAX, 32'h0098_9680, RESP_OKAY);
    axi_rd(OFF_MIN, 32'h0, RESP_OKAY);
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
    axi_wr(8'h24, 32'h1, RESP_SLVERR);
    axi_wr(OFF_STAT, 32'hF, RESP_OKAY);
  endtask
  task automatic t_depth(input logic [5:0] dp);
    axi_wr(OFF_CTRL, mk_ctrl(dp, PMODE_OFF, SAVE_PERM, 1'b0, 3'h3), RESP_OKAY);
    wait_pos(3, 32'd5000);
    chk({31'h0, gap >= dp * STEP && gap <= dp * STEP + 200}, 32'h1);
  endtask
  task automatic t_arith();
    axi_wr(OFF_SCALE, 32'h7D0, RESP_OKAY);
    axi_wr(OFF_OFFSET, 32'hFFFF_FC18, RESP_OKAY);
    wait_pos(2, 32'd8000);
    axi_wr(OFF_SCALE, 32'h3E8, RESP_OKAY);
    axi_wr(OFF_OFFSET, 32'h0, RESP_OKAY);
    axi_wr(OFF_CTRL, mk_ctrl(6'h8, PMODE_OFF, SAVE_PERM, 1'b1, 3'h3), RESP_OKAY);
    wait_pos(2, 32'd9995000);
    axi_wr(OFF_CTRL, CTRL_DEF, RESP_OKAY);
  endtask
  task automatic t_limits();
    axi_wr(OFF_MIN, 32'd5001, RESP_OKAY);
    wait_pos(2, 32'h0);
    axi_wr(OFF_MIN, 32'h0, RESP_OKAY);
    axi_wr(OFF_MAX, 32'd4999, RESP_OKAY);
    wait_pos(2, 32'h0);
    axi_wr(OFF_MAX, 32'd5000, RESP_OKAY);
    wait_pos(2, 32'd5000);
    axi_wr(OFF_MAX, MAX_DEF, RESP_OKAY);
  endtask
  task automatic t_res();
    logic [31:0] tbl [6] = '{32'd500000, 32'd50000, 32'd5000, 32'd500, 32'd50, 32'd5};
    for (int c = 1; c <= 6; c++) begin
      axi_wr(OFF_CTRL, mk_ctrl(6'h8, PMODE_OFF, SAVE_PERM, 1'b0, c[2:0]), RESP_OKAY);
      wait_pos(2, tbl[c - 1]);
    end
    axi_wr(OFF_CTRL, CTRL_DEF, RESP_OKAY);
  endtask
  task automatic t_preset();
    axi_wr(OFF_OFFSET, 32'h7, RESP_OKAY);
    axi_wr(OFF_SCALE, 32'h7D0, RESP_OKAY);
    axi_wr(OFF_PRESET, 32'h64, RESP_OKAY);
    pulse_sw();
    wait_pos(2, 32'd10014);
    chk({31'h0, preset_active}, 32'h0);
    axi_wr(OFF_CTRL, mk_ctrl(6'h8, PMODE_ON, SAVE_PERM, 1'b0, 3'h3), RESP_OKAY);
    pulse_sw();
    wait_pos(2, 32'd100);
    chk({31'h0, preset_active}, 32'h1);
    @(posedge clk) scan <= TAPE + 32'd1000;
    wait_pos(3, 32'd120);
    axi_wr(OFF_CTRL, mk_ctrl(6'h8, PMODE_ON, SAVE_PERM, 1'b0, 3'h4) | 32'h8000_0000, RESP_OKAY);
    wait_pos(2, 32'd12);
    chk({31'h0, preset_active}, 32'h1);
    axi_wr(OFF_CTRL, CTRL_DEF, RESP_OKAY);
    wait_pos(2, 32'd10034);
    chk({31'h0, preset_active}, 32'h0);
    axi_wr(OFF_CTRL, mk_ctrl(6'h8, PMODE_ON, SAVE_TEMP, 1'b0, 3'h3), RESP_OKAY);
    pulse_sw();
    wait_pos(2, 32'd100);
    axi_wr(OFF_CTRL, mk_ctrl(6'h8, PMODE_ON, SAVE_TEMP, 1'b0, 3'h3) | 32'h8000_0000, RESP_OKAY);
    wait_pos(2, 32'd10034);
    chk({31'h0, preset_active}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; scan = TAPE; sw = 1'b0;
    awaddr = 8'h0; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = 8'h0; arvalid = 1'b0; rready = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    wait_pos(2, 32'd5000);
    axi_rd(OFF_POS, 32'd5000, RESP_OKAY);
    t_depth(6'h4);
    t_depth(6'h20);
    t_depth(6'h8);
    t_arith();
    t_limits();
    t_res();
    t_preset();
    end_sim();
  end
endmodule // tb
`default_nettype wire
